// [core/mmd_decode.sv]
// Memory map decode: ROM, dual-access RAM, overlay and vector table
// Function
// [R1] 4K x 16 mask ROM decoded in program space
// [R2] Boot pin low at reset: fetch ROM FF80h
// [R3] ROM split into reserved, boot, tables, vectors
// [R4] Users keep FF00h-FF7Fh free for factory test
// [R5] 16K RAM made of two 8K blocks
// [R6] Each block: two reads or read+write per cycle
// [R7] RAM decoded in data space 0060h-3FFFh
// [R8] Overlay bit maps RAM into program space too
// [R9] Overlay: lower 16K of every page is RAM
// [R10] Taken event loads PC with vector address
// [R11] Vectors spaced four words apart
// [R12] After reset, vectors sit at FF80h
// [R13] Pointer write relocates table to 128-word page
// [R14] Later vectors fetched from newly selected page
// [R15] Reset sets pointer to ones; reset at FF80h
// [R16] Vector address is pointer then number times four
`timescale 1ns/1ns
`default_nettype none
module mmd_decode
  import mmd_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic boot_select_pin,
  input wire logic prog_req,
  input wire logic [PROG_ADDR_W-1:0] prog_addr,
  input wire logic data_a_req,
  input wire logic [DATA_ADDR_W-1:0] data_a_addr,
  input wire logic data_b_req,
  input wire logic data_b_wr,
  input wire logic [DATA_ADDR_W-1:0] data_b_addr,
  input wire logic mode_we,
  input wire logic [WORD_W-1:0] mode_wdata,
  input wire logic vec_take,
  input wire logic [VEC_NUM_W-1:0] vec_num,
  output mmd_target_t prog_target,
  output mmd_region_t prog_region,
  output logic [ROM_OFF_W-1:0] prog_rom_off,
  output logic prog_ram_blk,
  output logic [RAM_OFF_W-1:0] prog_ram_off,
  output mmd_target_t data_a_target,
  output logic data_a_ram_blk,
  output logic [RAM_OFF_W-1:0] data_a_ram_off,
  output mmd_target_t data_b_target,
  output logic data_b_ram_blk,
  output logic [RAM_OFF_W-1:0] data_b_ram_off,
  output logic data_b_ram_wr,
  output logic ram_conflict,
  output logic [WORD_W-1:0] mode_rdata,
  output logic boot_from_rom,
  output logic pc_load,
  output logic [WORD_W-1:0] pc_vector
);

  // All state of the decoder in one record
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic [1:0] settle;
    logic boot_rom;
    logic [MODE_PTR_W-1:0] vptr;
    logic ovl;
    mmd_target_t p_tgt;
    mmd_region_t p_rgn;
    logic [ROM_OFF_W-1:0] p_rom_off;
    logic p_blk;
    logic [RAM_OFF_W-1:0] p_off;
    mmd_target_t a_tgt;
    logic a_blk;
    logic [RAM_OFF_W-1:0] a_off;
    mmd_target_t b_tgt;
    logic b_blk;
    logic [RAM_OFF_W-1:0] b_off;
    logic b_wr;
    logic conflict;
    logic pc_load;
    logic [WORD_W-1:0] pc_vec;
  } mmd_state_t;

  mmd_state_t st_reg;
  mmd_state_t st_next;
  mmd_rom_if rif ();

  logic [15:0] p_low;
  logic [3:0] p_page;
  logic p_ram_hit;
  logic a_ram_hit;
  logic b_ram_hit;
  logic [1:0] blk0_cnt;
  logic [1:0] blk1_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Program address split into page and in-page word
  assign p_page = prog_addr[PROG_ADDR_W-1:16];
  assign p_low = prog_addr[15:0];

  // ROM answers only in page 0 and only when booted from ROM
  assign rif.en = prog_req && (p_page == 4'h0) && st_reg.boot_rom; // [R2]
  assign rif.addr = p_low;

  mmd_rom_decode u_rom_decode (
    .rif (rif)
  );

  ////////////////////////////////////////////////////////////////////////
  // RAM hits on each bus
  // Overlay covers the low 16K of every page, page 0 included
  assign p_ram_hit = prog_req && st_reg.ovl && (p_low <= RAM_OVL_HI); // [R8] [R9]
  assign a_ram_hit = data_a_req && (data_a_addr >= RAM_DATA_LO)
    && (data_a_addr <= RAM_DATA_HI); // [R7]
  assign b_ram_hit = data_b_req && (data_b_addr >= RAM_DATA_LO)
    && (data_b_addr <= RAM_DATA_HI); // [R7]

  // Accesses landing on each 8K block this cycle
  always_comb begin
    blk0_cnt = 2'h0;
    blk1_cnt = 2'h0;
    if (p_ram_hit) begin
      if (p_low[RAM_BLK_BIT]) blk1_cnt = blk1_cnt + 2'h1;
      else blk0_cnt = blk0_cnt + 2'h1;
    end
    if (a_ram_hit) begin
      if (data_a_addr[RAM_BLK_BIT]) blk1_cnt = blk1_cnt + 2'h1;
      else blk0_cnt = blk0_cnt + 2'h1;
    end
    if (b_ram_hit) begin
      if (data_b_addr[RAM_BLK_BIT]) blk1_cnt = blk1_cnt + 2'h1;
      else blk0_cnt = blk0_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Boot pin comes from outside; two stages before use
    st_next.pin_s1 = boot_select_pin;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pc_load = 1'b0;

    // Boot strap caught from the synchroniser two cycles after reset release
    if (st_reg.settle != BOOT_SETTLE_CYC) begin
      st_next.settle = st_reg.settle + 2'h1;
      if (st_reg.settle + 2'h1 == BOOT_SETTLE_CYC) begin
        st_next.boot_rom = ~st_reg.pin_s2; // [R2]
        // Reset vector ignores the pointer and is always FF80h
        st_next.pc_load = 1'b1; // [R10] [R15]
        st_next.pc_vec = VEC_RESET_ADDR; // [R2] [R12] [R15]
      end
    end else if (vec_take) begin
      // Pointer on top, number scaled by four below it
      st_next.pc_load = 1'b1; // [R10]
      st_next.pc_vec = {st_reg.vptr, vec_num,
        {VEC_SPACING_SHIFT{1'b0}}}; // [R11] [R14] [R16]
    end

    // Software update of the mode register fields
    if (mode_we) begin
      st_next.vptr = mode_wdata[MODE_PTR_LSB +: MODE_PTR_W]; // [R13]
      st_next.ovl = mode_wdata[MODE_OVL_BIT]; // [R8]
    end

    // Program bus: ROM beats overlay RAM beats external
    st_next.p_tgt = TG_NONE;
    st_next.p_rgn = RG_NONE;
    st_next.p_rom_off = '0;
    st_next.p_blk = 1'b0;
    st_next.p_off = '0;
    if (rif.hit) begin
      st_next.p_tgt = TG_ROM; // [R1]
      st_next.p_rgn = rif.region; // [R3]
      st_next.p_rom_off = rif.offset;
    end else if (p_ram_hit) begin
      st_next.p_tgt = TG_RAM; // [R8] [R9]
      st_next.p_blk = p_low[RAM_BLK_BIT]; // [R5]
      st_next.p_off = p_low[RAM_OFF_W-1:0];
    end else if (prog_req) begin
      st_next.p_tgt = TG_EXT; // [R9]
    end

    // Data bus A: read port
    st_next.a_tgt = TG_NONE;
    st_next.a_blk = 1'b0;
    st_next.a_off = '0;
    if (a_ram_hit) begin
      st_next.a_tgt = TG_RAM; // [R7]
      st_next.a_blk = data_a_addr[RAM_BLK_BIT]; // [R5]
      st_next.a_off = data_a_addr[RAM_OFF_W-1:0];
    end else if (data_a_req && data_a_addr < RAM_DATA_LO) begin
      st_next.a_tgt = TG_MMR;
    end else if (data_a_req) begin
      st_next.a_tgt = TG_EXT;
    end

    // Data bus B: read or write port
    st_next.b_tgt = TG_NONE;
    st_next.b_blk = 1'b0;
    st_next.b_off = '0;
    st_next.b_wr = 1'b0;
    if (b_ram_hit) begin
      st_next.b_tgt = TG_RAM; // [R7]
      st_next.b_blk = data_b_addr[RAM_BLK_BIT]; // [R5]
      st_next.b_off = data_b_addr[RAM_OFF_W-1:0];
      st_next.b_wr = data_b_wr; // [R6]
    end else if (data_b_req && data_b_addr < RAM_DATA_LO) begin
      st_next.b_tgt = TG_MMR;
    end else if (data_b_req) begin
      st_next.b_tgt = TG_EXT;
    end

    // A block serves two accesses a cycle; a third must be retried
    st_next.conflict = (blk0_cnt > 2'(RAM_ACCESS_PER_BLK))
      || (blk1_cnt > 2'(RAM_ACCESS_PER_BLK)); // [R6]
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset acts regardless of clock enable, which otherwise freezes everything
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
      // Strap keeps flowing through the synchroniser while reset is held
      st_reg.pin_s1 <= boot_select_pin; // [R2]
      st_reg.pin_s2 <= st_reg.pin_s1;
      st_reg.vptr <= MODE_PTR_RST; // [R12] [R15]
      st_reg.ovl <= MODE_OVL_RST;
      st_reg.boot_rom <= 1'b1;
      st_reg.p_tgt <= TG_NONE;
      st_reg.p_rgn <= RG_NONE;
      st_reg.a_tgt <= TG_NONE;
      st_reg.b_tgt <= TG_NONE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state record
  assign prog_target = st_reg.p_tgt;
  assign prog_region = st_reg.p_rgn;
  assign prog_rom_off = st_reg.p_rom_off;
  assign prog_ram_blk = st_reg.p_blk;
  assign prog_ram_off = st_reg.p_off;
  assign data_a_target = st_reg.a_tgt;
  assign data_a_ram_blk = st_reg.a_blk;
  assign data_a_ram_off = st_reg.a_off;
  assign data_b_target = st_reg.b_tgt;
  assign data_b_ram_blk = st_reg.b_blk;
  assign data_b_ram_off = st_reg.b_off;
  assign data_b_ram_wr = st_reg.b_wr;
  assign ram_conflict = st_reg.conflict;
  assign boot_from_rom = st_reg.boot_rom;
  assign pc_load = st_reg.pc_load;
  assign pc_vector = st_reg.pc_vec;

  // Mode register read-back; unused bits read zero
  always_comb begin
    mode_rdata = '0;
    mode_rdata[MODE_PTR_LSB +: MODE_PTR_W] = st_reg.vptr;
    mode_rdata[MODE_BOOT_BIT] = ~st_reg.boot_rom;
    mode_rdata[MODE_OVL_BIT] = st_reg.ovl;
  end

endmodule : mmd_decode
`default_nettype wire

// [core/mmd_pkg.sv]
// Constants and types for the on-chip memory map and vector decode
package mmd_pkg;

  // Bus widths
  localparam int PROG_ADDR_W = 20;
  localparam int DATA_ADDR_W = 16;
  localparam int WORD_W = 16;

  // Mask ROM window in program page 0
  localparam int ROM_WORDS = 4096;
  localparam int ROM_OFF_W = 12;
  localparam logic [15:0] ROM_BASE = 16'hF000;
  localparam logic [15:0] ROM_BOOT_BASE = 16'hF800;
  localparam logic [15:0] ROM_MULAW_BASE = 16'hFC00;
  localparam logic [15:0] ROM_ALAW_BASE = 16'hFD00;
  localparam logic [15:0] ROM_SINE_BASE = 16'hFE00;
  localparam logic [15:0] ROM_TEST_BASE = 16'hFF00;
  localparam logic [15:0] ROM_VEC_BASE = 16'hFF80;
  localparam int ROM_TEST_WORDS = 128;

  // Dual-access RAM
  localparam int RAM_BLK_WORDS = 8192;
  localparam int RAM_OFF_W = 13;
  localparam int RAM_BLK_BIT = 13;
  localparam int RAM_ACCESS_PER_BLK = 2;
  localparam logic [15:0] RAM_DATA_LO = 16'h0060;
  localparam logic [15:0] RAM_DATA_HI = 16'h3FFF;
  localparam logic [15:0] RAM_OVL_HI = 16'h3FFF;

  // Vector table
  localparam logic [15:0] VEC_RESET_ADDR = 16'hFF80;
  localparam int VEC_NUM_W = 5;
  localparam int VEC_SPACING_SHIFT = 2;
  localparam int VEC_PAGE_WORDS = 128;

  // Processor mode register layout
  localparam int MODE_PTR_LSB = 7;
  localparam int MODE_PTR_W = 9;
  localparam int MODE_BOOT_BIT = 6;
  localparam int MODE_OVL_BIT = 5;
  localparam logic [MODE_PTR_W-1:0] MODE_PTR_RST = 9'h1FF;
  localparam logic MODE_OVL_RST = 1'b0;

  // Cycles after reset release before the boot pin is trusted
  localparam logic [1:0] BOOT_SETTLE_CYC = 2'h2;

  typedef enum logic [2:0] {
    RG_NONE, RG_RSVD, RG_BOOT, RG_MULAW, RG_ALAW, RG_SINE, RG_TEST, RG_VEC
  } mmd_region_t;

  typedef enum logic [2:0] {
    TG_NONE, TG_MMR, TG_RAM, TG_ROM, TG_EXT
  } mmd_target_t;

endpackage : mmd_pkg

// [core/mmd_rom_if.sv]
// Carrier between the top decode and the ROM region decoder
`timescale 1ns/1ns
`default_nettype none
interface mmd_rom_if;
  import mmd_pkg::*;
  logic en;
  logic [15:0] addr;
  logic hit;
  mmd_region_t region;
  logic [ROM_OFF_W-1:0] offset;
  modport dec (input en, input addr, output hit, output region,
    output offset);
  modport usr (output en, output addr, input hit, input region,
    input offset);
endinterface : mmd_rom_if
`default_nettype wire

// [core/mmd_rom_decode.sv]
// ROM region decoder: splits the 4K-word ROM window into its regions
`timescale 1ns/1ns
`default_nettype none
module mmd_rom_decode
  import mmd_pkg::*;
(
  mmd_rom_if.dec rif
);

  ////////////////////////////////////////////////////////////////////////
  // Region lookup, checked from the top of the window downward
  always_comb begin
    rif.hit = 1'b0;
    rif.region = RG_NONE;
    rif.offset = rif.addr[ROM_OFF_W-1:0];
    if (rif.en && rif.addr >= ROM_BASE) begin
      rif.hit = 1'b1; // [R1]
      if (rif.addr >= ROM_VEC_BASE) begin
        rif.region = RG_VEC; // [R3]
      end else if (rif.addr >= ROM_TEST_BASE) begin
        rif.region = RG_TEST; // [R3]
      end else if (rif.addr >= ROM_SINE_BASE) begin
        rif.region = RG_SINE; // [R3]
      end else if (rif.addr >= ROM_ALAW_BASE) begin
        rif.region = RG_ALAW; // [R3]
      end else if (rif.addr >= ROM_MULAW_BASE) begin
        rif.region = RG_MULAW; // [R3]
      end else if (rif.addr >= ROM_BOOT_BASE) begin
        rif.region = RG_BOOT; // [R3]
      end else begin
        rif.region = RG_RSVD; // [R3]
      end
    end
  end

endmodule : mmd_rom_decode
`default_nettype wire

// [tb/mmd_core_bfm.sv]
// Core-side model that raises taken interrupts and traps
`timescale 1ns/1ns
`default_nettype none
module mmd_core_bfm (
  input wire logic mclk,
  output logic vec_take,
  output logic [4:0] vec_num
);
  initial begin
    vec_take = 1'b0;
    vec_num = 5'h00;
  end
  // Called just after an edge; held for the whole cycle
  task raise(input logic on, input logic [4:0] n);
    vec_take = on;
    vec_num = n;
  endtask : raise
endmodule : mmd_core_bfm
`default_nettype wire

// [tb/mmd_decode_properties.sv]
// Timing checks of the decode outputs against their requests
`timescale 1ns/1ns
`default_nettype none
module mmd_decode_properties
  import mmd_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic boot_select_pin,
  input wire logic prog_req,
  input wire logic [19:0] prog_addr,
  input wire logic data_a_req,
  input wire logic [15:0] data_a_addr,
  input wire logic mode_we,
  input wire logic [15:0] mode_wdata,
  input wire logic vec_take,
  input wire logic [4:0] vec_num,
  input wire mmd_target_t prog_target,
  input wire mmd_region_t prog_region,
  input wire mmd_target_t data_a_target,
  input wire logic data_a_ram_blk,
  input wire logic [12:0] data_a_ram_off,
  input wire logic [15:0] mode_rdata,
  input wire logic boot_from_rom,
  input wire logic pc_load,
  input wire logic [15:0] pc_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic armed_reg;
  // Vectors count only once the boot pulse has been seen
  always_ff @(posedge mclk) armed_reg <= sys_rst ? 1'b0 : armed_reg | pc_load;
  sequence boot_rel;
    $fell(sys_rst) && clk_en ##1 clk_en;
  endsequence
  AST_ROM_HIT: assert property (clk_en && prog_req && boot_from_rom &&
    prog_addr[19:12] == 8'h0F |=> prog_target == TG_ROM) else $error("rom");
  AST_VEC_REG: assert property (clk_en && prog_req && boot_from_rom &&
    prog_addr[19:7] == 13'h01FF |=> prog_region == RG_VEC) else $error("reg");
  AST_BOOT_REG: assert property (clk_en && prog_req && boot_from_rom &&
    prog_addr[19:10] == 10'h03E |=> prog_region == RG_BOOT) else $error("bl");
  AST_DATA_RAM: assert property (clk_en && data_a_req &&
    data_a_addr >= 16'h0060 && data_a_addr <= 16'h3FFF |=>
    data_a_target == TG_RAM &&
    {data_a_ram_blk, data_a_ram_off} == $past(data_a_addr[13:0]))
    else $error("dram");
  AST_DATA_EXT: assert property (clk_en && data_a_req &&
    data_a_addr > 16'h3FFF |=> data_a_target == TG_EXT) else $error("dext");
  AST_OVL: assert property (clk_en && prog_req && mode_rdata[5] &&
    prog_addr[15:14] == 2'h0 |=> prog_target == TG_RAM) else $error("ov");
  AST_NO_OVL: assert property (clk_en && prog_req && !mode_rdata[5] &&
    prog_addr[15:14] == 2'h0 |=> prog_target == TG_EXT) else $error("nov");
  AST_MODE: assert property (clk_en && mode_we |=>
    {mode_rdata[15:7], mode_rdata[5]} ==
    {$past(mode_wdata[15:7]), $past(mode_wdata[5])}) else $error("pm");
  AST_VEC: assert property (clk_en && vec_take && (armed_reg || pc_load)
    |=> pc_load && pc_vector == {$past(mode_rdata[15:7]),
    $past(vec_num), 2'h0}) else $error("vec");
  AST_RST: assert property ($fell(sys_rst) |->
    mode_rdata[15:7] == 9'h1FF && !pc_load && boot_from_rom)
    else $error("reset");
  AST_BOOT: assert property (boot_rel |=> pc_load &&
    pc_vector == 16'hFF80 && boot_from_rom == !boot_select_pin)
    else $error("bt");
endmodule : mmd_decode_properties
bind mmd_decode mmd_decode_properties u_props (.*);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the memory map and vector decode
`timescale 1ns/1ns
`default_nettype none
module tb;
  import mmd_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1, clk_en = 1'b1, boot_select_pin = 1'b0;
  logic prog_req = 1'b0, data_a_req = 1'b0, data_b_req = 1'b0;
  logic data_b_wr = 1'b0, mode_we = 1'b0, vec_take;
  logic [19:0] prog_addr = 20'h0;
  logic [15:0] data_a_addr = 16'h0, data_b_addr = 16'h0, mode_wdata = 16'h0;
  logic [4:0] vec_num;
  mmd_target_t prog_target, data_a_target, data_b_target;
  mmd_region_t prog_region;
  logic [11:0] prog_rom_off;
  logic [12:0] prog_ram_off, data_a_ram_off, data_b_ram_off;
  logic prog_ram_blk, data_a_ram_blk, data_b_ram_blk, data_b_ram_wr;
  logic ram_conflict, boot_from_rom, pc_load;
  logic [15:0] mode_rdata, pc_vector;
  int mismatches = 0, cmp_count = 0;
  logic [31:0] rng = 32'h25;
  logic ovl_m, bfr_m;
  logic [8:0] ptr_m;
  always #5 mclk = ~mclk;
  mmd_decode DUT (.*);
  mmd_core_bfm core (.mclk(mclk), .vec_take(vec_take), .vec_num(vec_num));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  task conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [39:0] e, input logic [39:0] s);
    cmp_count++;
    if (e !== s) begin
      $display("wrong value %s expected %0h seen %0h", n, e, s);
      mismatches++;
    end
  endtask : chk
  // Reference decode from the map; ROM beats RAM in program space
  function automatic mmd_target_t tp(logic [19:0] a);
    if (a[19:12] == 8'h0F && bfr_m) return TG_ROM;
    return (ovl_m && a[15:14] == 2'h0) ? TG_RAM : TG_EXT;
  endfunction : tp
  function automatic mmd_target_t td(logic [15:0] a);
    return a < 16'h0060 ? TG_MMR : (a <= 16'h3FFF ? TG_RAM : TG_EXT);
  endfunction : td
  function automatic mmd_region_t rg(logic [15:0] a);
    return a < 16'hF800 ? RG_RSVD : a < 16'hFC00 ? RG_BOOT :
      a < 16'hFD00 ? RG_MULAW : a < 16'hFE00 ? RG_ALAW :
      a < 16'hFF00 ? RG_SINE : a < 16'hFF80 ? RG_TEST : RG_VEC;
  endfunction : rg
  task rst(input logic pin);
    boot_select_pin = pin;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    chk("rst", {1'b1, 16'hFF80}, {boot_from_rom, mode_rdata});
    repeat (2) @(posedge mclk);
    #1 chk("boot", {1'b1, 16'hFF80, !pin, 9'h1FF, pin, 6'h0},
      {pc_load, pc_vector, boot_from_rom, mode_rdata});
    ovl_m = 1'b0;
    ptr_m = 9'h1FF;
    bfr_m = !pin;
  endtask : rst
  task traffic(input int n);
    logic [31:0] x, y;
    mmd_target_t ep, ea, eb;
    for (int i = 0; i < n; i++) begin
      x = xs();
      y = xs();
      prog_req = x[26];
      data_a_req = x[27];
      data_b_req = x[29];
      data_b_wr = x[30];
      prog_addr = x[23:22] == 2'h0 ? {8'h0F, x[11:0]} :
        x[23:22] == 2'h1 ? {x[19:16], 2'h0, x[13:0]} : x[19:0];
      data_a_addr = y[15] ? {2'h0, prog_addr[13], y[12:0]} : y[31:16];
      data_b_addr = x[24] ? {2'h0, prog_addr[13], y[28:16]} : y[15:0];
      mode_we = x[31:28] == 4'h0;
      mode_wdata = y[31:16];
      @(posedge mclk);
      #1;
      ep = prog_req ? tp(prog_addr) : TG_NONE;
      ea = data_a_req ? td(data_a_addr) : TG_NONE;
      eb = data_b_req ? td(data_b_addr) : TG_NONE;
      chk("tgt", {ep, ea, eb}, {prog_target, data_a_target, data_b_target});
      // Factory test words are read only, never written by the bench
      if (ep == TG_ROM) chk("rom", {rg(prog_addr[15:0]), prog_addr[11:0]},
        {prog_region, prog_rom_off});
      if (ep == TG_RAM) chk("pram", prog_addr[13:0], {prog_ram_blk, prog_ram_off});
      if (ea == TG_RAM) chk("aram", data_a_addr[13:0], {data_a_ram_blk, data_a_ram_off});
      if (eb == TG_RAM) chk("bram", {data_b_wr, data_b_addr[13:0]},
        {data_b_ram_wr, data_b_ram_blk, data_b_ram_off});
      chk("conf", ep == TG_RAM && ea == TG_RAM && eb == TG_RAM &&
        data_a_addr[13] == prog_addr[13] &&
        data_b_addr[13] == prog_addr[13], ram_conflict);
      // A write taken at this edge already shows in the read-back
      if (mode_we) begin
        ptr_m = mode_wdata[15:7];
        ovl_m = mode_wdata[5];
      end
      chk("mode", {ptr_m, !bfr_m, ovl_m, 5'h0}, mode_rdata);
    end
    {prog_req, data_a_req, data_b_req, mode_we} = 4'h0;
  endtask : traffic
  // Back to back vectors; one pointer write lands beside a vector
  task vectors();
    for (int n = 0; n < 32; n++) begin
      core.raise(1'b1, n[4:0]);
      mode_we = n == 9;
      mode_wdata = 16'h0120;
      @(posedge mclk);
      #1 mode_we = 1'b0;
      chk("vec", {1'b1, ptr_m, n[4:0], 2'h0}, {pc_load, pc_vector});
      if (n == 9) {ptr_m, ovl_m} = {9'h002, 1'b1};
    end
    core.raise(1'b0, 5'h00);
    @(posedge mclk);
    #1 chk("pulse", 1'b0, pc_load);
    clk_en = 1'b0;
    mode_we = 1'b1;
    mode_wdata = 16'h0000;
    repeat (3) @(posedge mclk);
    #1 chk("hold", {ptr_m, !bfr_m, ovl_m, 5'h0}, mode_rdata);
    {clk_en, mode_we} = 2'b10;
  endtask : vectors
  initial begin
    #900000 mismatches++;
    conclude();
  end
  initial begin
    rst(1'b0);
    traffic(300);
    vectors();
    traffic(100);
    rst(1'b1);
    traffic(200);
    vectors();
    conclude();
  end
endmodule : tb
`default_nettype wire
